/* File: rtl/ring_mux_pkg.sv */
// constants shared by the ring adapter multiplexer interrupt and parity logic
`default_nettype none
package ring_mux_pkg;
    localparam int NUM_POS = 4;
    localparam int POS_W = 2;
    localparam logic [7:0] ADAPTER_LEVEL1_FLAG_ADDR = 8'h7E; // address of adapter level 1 flag register
    localparam logic [7:0] LID_TYPE_B_BASE = 8'h20; // type B line identifier base
    // command codes
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_CONNECT = 3'b001,
        CMD_DISCONNECT = 3'b010,
        CMD_MASK = 3'b011,
        CMD_UNMASK = 3'b100,
        CMD_PROG_RESET = 3'b101,
        CMD_GET_L1 = 3'b110,
        CMD_GET_COMPLETION = 3'b111
    } cmd_t;
    // completion word bit positions
    localparam int CC_MASKED = 0;
    localparam int CC_PAR_B0 = 1;
    localparam int CC_PAR_B1 = 2;
    localparam int CC_DISC_DONE = 3;
    localparam int CC_DIRECT = 4;
    localparam int CC_W = 8;
    // level 1 status bit positions
    localparam int L1_DISCONNECT = 0;
    localparam int L1_PROGRAMMED_IO_DISABLE_FLAG = 1;
    localparam int L1_W = 8;
    localparam logic [L1_W-1:0] L1_RESET = 8'h03; // disconnected, io disabled
endpackage : ring_mux_pkg
`default_nettype wire

/* File: rtl/bus_parity_check.sv */
// per byte lane odd parity checker for adapter bus data
`default_nettype none
module bus_parity_check
    import ring_mux_pkg::*;
#(
    parameter int LANES = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [LANES*8-1:0] data,
    input wire logic [LANES-1:0] par,
    input wire logic strobe,
    output logic [LANES-1:0] err_reg
);
    // ----------------------------------------
    // lane checkers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // odd parity over data byte plus parity bit
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    err_reg[g] <= 1'b0;
                end else begin
                    err_reg[g] <= strobe && !(^{data[g*8 +: 8], par[g]});
                end
            end
        end
    endgenerate
endmodule : bus_parity_check
`default_nettype wire

/* File: rtl/ring_mux_connect_mask_parity.sv */
// interrupt gating, connect state, mask and adapter bus parity reporting
// What this block does
// - connect command clears disconnect and programmed io disable flags
// - per position routing bit sends that position's interrupts to maintenance
// - mask in connected state blocks every routed position interrupt
// - disconnect raises a completion interrupt that ignores the mask
// - with mask active, nothing more after disconnect interrupt serviced
// - disconnect sets adapter level 1 flag; level 1 read clears it
// - unmask removes the mask so pending interrupts deliver again
// - programmed reset clears the mask
// - completion response reports whether interrupts are masked
// - parity checker examines adapter to multiplexer data
// - parity error logs level 2 status and sets completion bits
// - parity error computes type B line identifier of source position
// - parity checked per byte lane, either or both lanes
// - read parity error gives level 4 interrupt, never level 1
`default_nettype none
module ring_mux_connect_mask_parity
    import ring_mux_pkg::*;
#(
    parameter int NPOS = NUM_POS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] cmd,
    input wire logic cmd_valid,
    input wire logic [NPOS-1:0] maintenance_routing_bit,
    input wire logic [NPOS-1:0] interrupt_request_register,
    input wire logic [15:0] adp_data,
    input wire logic [1:0] adp_par,
    input wire logic adp_rd_strobe,
    input wire logic [POS_W-1:0] adp_pos,
    input wire logic int_serviced,
    output logic maint_int_reg,
    output logic level4_interrupt_reg,
    output logic level1_interrupt_reg,
    output logic [L1_W-1:0] l1_status_reg,
    output logic adapter_level1_flag_reg,
    output logic [7:0] adapter_level1_flag_addr_reg,
    output logic [CC_W-1:0] completion_reg,
    output logic [7:0] l2_status_reg,
    output logic [7:0] line_identifier_reg,
    output logic connected_reg,
    output logic masked_reg
);
    // ----------------------------------------
    // input capture
    // ----------------------------------------
    logic [15:0] data_s1, data_s2;
    logic [1:0] par_s1, par_s2;
    logic rd_s1, rd_s2;
    logic [POS_W-1:0] pos_s1, pos_s2, pos_d;
    logic [1:0] perr;
    logic disc_pend_reg;
    logic [NPOS-1:0] direct_pend;
    logic any_direct;
    logic is_cmd;

    // two stage synchroniser for adapter bus pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
            par_s1 <= 2'h0;
            par_s2 <= 2'h0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            pos_s1 <= '0;
            pos_s2 <= '0;
            pos_d <= '0;
        end else begin
            data_s1 <= adp_data;
            data_s2 <= data_s1;
            par_s1 <= adp_par;
            par_s2 <= par_s1;
            rd_s1 <= adp_rd_strobe;
            rd_s2 <= rd_s1;
            pos_s1 <= adp_pos;
            pos_s2 <= pos_s1;
            pos_d <= pos_s2; // aligned with checker output
        end
    end

    // dedicated checker on adapter to multiplexer data
    bus_parity_check #(.LANES(2)) u_par (
        .clk(clk),
        .rstn(rstn),
        .data(data_s2),
        .par(par_s2),
        .strobe(rd_s2),
        .err_reg(perr)
    );

    assign is_cmd = cmd_valid;
    assign direct_pend = interrupt_request_register & maintenance_routing_bit;
    assign any_direct = |direct_pend;

    // ----------------------------------------
    // connect state and mask
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            connected_reg <= 1'b0;
        end else if (is_cmd && cmd == CMD_CONNECT) begin
            connected_reg <= 1'b1;
        end else if (is_cmd && (cmd == CMD_DISCONNECT || cmd == CMD_PROG_RESET)) begin
            connected_reg <= 1'b0;
        end
    end

    // mask persists until unmask or programmed reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            masked_reg <= 1'b0;
        end else if (is_cmd && (cmd == CMD_UNMASK || cmd == CMD_PROG_RESET)) begin
            masked_reg <= 1'b0;
        end else if (is_cmd && cmd == CMD_MASK) begin
            masked_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // level 1 status and adapter level 1 flag
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            l1_status_reg <= L1_RESET; // disconnected, io disabled
        end else if (is_cmd && cmd == CMD_CONNECT) begin
            l1_status_reg[L1_DISCONNECT] <= 1'b0;
            l1_status_reg[L1_PROGRAMMED_IO_DISABLE_FLAG] <= 1'b0;
        end else if (is_cmd && cmd == CMD_DISCONNECT) begin
            l1_status_reg[L1_DISCONNECT] <= 1'b1;
            l1_status_reg[L1_PROGRAMMED_IO_DISABLE_FLAG] <= 1'b1;
        end
    end

    // flag set by disconnect wins over a clearing read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adapter_level1_flag_reg <= 1'b0;
            adapter_level1_flag_addr_reg <= 8'h00;
        end else if (is_cmd && cmd == CMD_DISCONNECT) begin
            adapter_level1_flag_reg <= 1'b1;
            adapter_level1_flag_addr_reg <= ADAPTER_LEVEL1_FLAG_ADDR;
        end else if (is_cmd && cmd == CMD_GET_L1) begin
            adapter_level1_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // maintenance interrupt
    // ----------------------------------------
    // disconnect completion pending until serviced
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disc_pend_reg <= 1'b0;
        end else if (is_cmd && cmd == CMD_DISCONNECT) begin
            disc_pend_reg <= 1'b1;
        end else if (int_serviced) begin
            disc_pend_reg <= 1'b0;
        end
    end

    // direct interrupts gated by mask, disconnect bypasses it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            maint_int_reg <= 1'b0;
        end else begin
            maint_int_reg <= disc_pend_reg || (connected_reg && !masked_reg && any_direct);
        end
    end

    // ----------------------------------------
    // parity error handling
    // ----------------------------------------
    // read parity error: level 4 only, level 1 never raised
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level4_interrupt_reg <= 1'b0;
            level1_interrupt_reg <= 1'b0;
        end else begin
            if (|perr) begin
                level4_interrupt_reg <= 1'b1;
            end else if (is_cmd && cmd == CMD_GET_COMPLETION) begin
                level4_interrupt_reg <= 1'b0;
            end
            level1_interrupt_reg <= 1'b0;
        end
    end

    // level 2 log and line identifier of source position
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            l2_status_reg <= 8'h00;
            line_identifier_reg <= 8'h00;
        end else if (|perr) begin
            l2_status_reg[1:0] <= l2_status_reg[1:0] | perr;
            l2_status_reg[5:4] <= pos_d;
            line_identifier_reg <= LID_TYPE_B_BASE | {6'h00, pos_d};
        end
    end

    // ----------------------------------------
    // command completion response
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            completion_reg <= 8'h00;
        end else begin
            completion_reg[CC_MASKED] <= masked_reg;
            if (|perr) begin
                completion_reg[CC_PAR_B0] <= completion_reg[CC_PAR_B0] | perr[0];
                completion_reg[CC_PAR_B1] <= completion_reg[CC_PAR_B1] | perr[1];
            end else if (is_cmd && cmd == CMD_GET_COMPLETION) begin
                completion_reg[CC_PAR_B0] <= 1'b0;
                completion_reg[CC_PAR_B1] <= 1'b0;
            end
            completion_reg[CC_DISC_DONE] <= disc_pend_reg;
            completion_reg[CC_DIRECT] <= any_direct;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_mask_blocks;
        @(posedge clk) disable iff (!rstn)
        (masked_reg && !disc_pend_reg) |=> !maint_int_reg;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("interrupt while masked");

    property p_disc_int;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && cmd == CMD_DISCONNECT) |=> ##1 maint_int_reg;
    endproperty
    a_disc_int: assert property (p_disc_int) else $error("no disconnect interrupt");

    property p_connect_clears;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && cmd == CMD_CONNECT) |=> (l1_status_reg[1:0] == 2'b00);
    endproperty
    a_connect_clears: assert property (p_connect_clears) else $error("connect left flags");

    property p_l1_flag;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && cmd == CMD_GET_L1 && !(cmd == CMD_DISCONNECT)) |=> !adapter_level1_flag_reg;
    endproperty
    a_l1_flag: assert property (p_l1_flag) else $error("level 1 flag not cleared");

    property p_unmask;
        @(posedge clk) disable iff (!rstn)
        (cmd_valid && (cmd == CMD_UNMASK || cmd == CMD_PROG_RESET)) |=> !masked_reg;
    endproperty
    a_unmask: assert property (p_unmask) else $error("mask not removed");

    property p_mask_report;
        @(posedge clk) disable iff (!rstn)
        1'b1 |=> (completion_reg[CC_MASKED] == $past(masked_reg));
    endproperty
    a_mask_report: assert property (p_mask_report) else $error("masked bit wrong");

    property p_par_l4;
        @(posedge clk) disable iff (!rstn)
        (|perr) |=> (level4_interrupt_reg && !level1_interrupt_reg);
    endproperty
    a_par_l4: assert property (p_par_l4) else $error("parity error interrupt wrong");

    property p_lid;
        @(posedge clk) disable iff (!rstn)
        (|perr) |=> (line_identifier_reg[1:0] == $past(pos_d));
    endproperty
    a_lid: assert property (p_lid) else $error("line identifier wrong");
endmodule : ring_mux_connect_mask_parity
`default_nettype wire

/* File: bench/ring_adapter_model.sv */
// behavioural ring adapter driving read data toward the multiplexer
`default_nettype none
module ring_adapter_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic par_test,
    input wire logic send,
    input wire logic [15:0] word,
    input wire logic [1:0] pos,
    output logic [15:0] adp_data,
    output logic [1:0] adp_par,
    output logic adp_rd_strobe,
    output logic [1:0] adp_pos,
    output logic self_test_ok,
    input wire logic command_block_request_bit,
    input wire logic open_close,
    output logic adp_int,
    output logic status_block_posted
);
    timeunit 1ns;
    timeprecision 1ns;
    logic block_busy_reg;
    // command block busy for one cycle per open or close, then status posted and interrupt raised
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            block_busy_reg <= 1'b0;
            status_block_posted <= 1'b0;
            adp_int <= 1'b0;
        end else begin
            block_busy_reg <= open_close;
            status_block_posted <= status_block_posted | block_busy_reg;
            adp_int <= (command_block_request_bit && !block_busy_reg) || block_busy_reg || status_block_posted;
        end
    end
    // self test runs on every reset, result shown once it ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            self_test_ok <= 1'b0;
        end else begin
            self_test_ok <= 1'b1;
        end
    end
    // one read transfer per send; idle data and parity lines toggle so nothing stale is seen, position lines hold
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adp_data <= 16'h0000;
            adp_par <= 2'b00;
            adp_rd_strobe <= 1'b0;
            adp_pos <= 2'b00;
        end else if (send) begin
            adp_rd_strobe <= 1'b1;
            adp_data <= word;
            adp_pos <= pos;
            adp_par <= par_test ? 2'b00 : {~^word[15:8], ~^word[7:0]};
        end else begin
            adp_rd_strobe <= 1'b0;
            adp_data <= ~adp_data;
            adp_par <= ~adp_par;
        end
    end
endmodule : ring_adapter_model
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for connect, mask and parity reporting
`default_nettype none
module tb
    import ring_mux_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, cmd_valid, int_serviced, par_test, send, self_test_ok;
    logic [2:0] cmd;
    logic [3:0] routing, irq;
    logic [15:0] word, adp_data;
    logic [1:0] pos, adp_par, adp_pos;
    logic adp_rd_strobe, maint_int, l4_int, l1_int, l1_flag, connected, masked;
    logic [7:0] l1_status, l1_addr, completion, l2_status, line_identifier;
    logic cb_req, open_close, adp_int, posted;
    int error_cnt = 0;
    int n_compared = 0;
    ring_mux_connect_mask_parity ring_mux_connect_mask_parity_inst (.clk(clk), .rstn(rstn), .cmd(cmd),
        .cmd_valid(cmd_valid), .maintenance_routing_bit(routing),
        .interrupt_request_register(irq | {3'b000, adp_int}),
        .adp_data(adp_data), .adp_par(adp_par), .adp_rd_strobe(adp_rd_strobe), .adp_pos(adp_pos),
        .int_serviced(int_serviced), .maint_int_reg(maint_int), .level4_interrupt_reg(l4_int),
        .level1_interrupt_reg(l1_int), .l1_status_reg(l1_status), .adapter_level1_flag_reg(l1_flag),
        .adapter_level1_flag_addr_reg(l1_addr), .completion_reg(completion), .l2_status_reg(l2_status),
        .line_identifier_reg(line_identifier), .connected_reg(connected), .masked_reg(masked));
    ring_adapter_model ring_adapter_model_inst (.clk(clk), .rstn(rstn), .par_test(par_test), .send(send),
        .word(word), .pos(pos), .adp_data(adp_data), .adp_par(adp_par), .adp_rd_strobe(adp_rd_strobe),
        .adp_pos(adp_pos), .self_test_ok(self_test_ok), .command_block_request_bit(cb_req),
        .open_close(open_close), .adp_int(adp_int), .status_block_posted(posted));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] b8(input logic x);
        return {7'h00, x};
    endfunction : b8
    task automatic conclude;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic issue(input cmd_t c);
        @(posedge clk);
        cmd <= c;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        settle(3);
    endtask : issue
    task automatic drive(input logic [3:0] r, input logic [3:0] v);
        @(posedge clk);
        routing <= r;
        irq <= v;
        settle(3);
    endtask : drive
    task automatic service;
        @(posedge clk);
        int_serviced <= 1'b1;
        @(posedge clk);
        int_serviced <= 1'b0;
        settle(3);
    endtask : service
    task automatic rd(input logic [15:0] w, input logic [1:0] p);
        @(posedge clk);
        word <= w;
        pos <= p;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        settle(1);
    endtask : rd
    // ------------------------------------------------------------
    // clock and test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        cmd = CMD_NONE;
        cmd_valid = 1'b0;
        int_serviced = 1'b0;
        par_test = 1'b0;
        send = 1'b0;
        word = 16'h0000;
        pos = 2'b00;
        routing = 4'hF;
        irq = 4'h0;
        cb_req = 1'b0;
        open_close = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        settle(1);
        chk("l1_status", 8'h03, l1_status);
        chk("self_test", 8'h01, b8(self_test_ok));
        issue(CMD_CONNECT);
        chk("l1_status", 8'h00, l1_status);
        for (int p = 0; p < 4; p++) begin
            drive(4'hF, 4'h1 << p);
            chk("direct_int", 8'h01, b8(maint_int));
            drive(4'hF, 4'h0);
            service();
        end
        drive(4'h0, 4'hF);
        chk("unrouted_int", 8'h00, b8(maint_int));
        drive(4'hF, 4'h0);
        service();
        issue(CMD_MASK);
        chk("cc_masked", 8'h01, b8(completion[CC_MASKED]));
        drive(4'hF, 4'hF);
        chk("masked_int", 8'h00, b8(maint_int));
        issue(CMD_DISCONNECT);
        chk("adapter_level1_flag_flag", 8'h01, b8(l1_flag));
        chk("adapter_level1_flag_addr", ADAPTER_LEVEL1_FLAG_ADDR, l1_addr);
        chk("disc_int", 8'h01, b8(maint_int));
        service();
        settle(5);
        chk("after_disc", 8'h00, b8(maint_int));
        issue(CMD_GET_L1);
        chk("adapter_level1_flag_flag", 8'h00, b8(l1_flag));
        issue(CMD_CONNECT);
        chk("mask_held", 8'h01, b8(masked));
        chk("masked_int", 8'h00, b8(maint_int));
        issue(CMD_UNMASK);
        chk("cc_masked", 8'h00, b8(completion[CC_MASKED]));
        chk("unmask_int", 8'h01, b8(maint_int));
        drive(4'hF, 4'h0);
        service();
        issue(CMD_MASK);
        drive(4'hF, 4'hF);
        issue(CMD_PROG_RESET);
        chk("masked", 8'h00, b8(masked));
        issue(CMD_CONNECT);
        chk("reset_int", 8'h01, b8(maint_int));
        drive(4'hF, 4'h0);
        service();
        @(posedge clk);
        par_test <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            issue(CMD_GET_COMPLETION);
            // lane 0 only, lane 1 only, then both lanes need parity one
            rd(k == 1 ? 16'h0100 : (k == 2 ? 16'h0001 : 16'h0000), 2'(k));
            for (int i = 0; i < 10 && l4_int !== 1'b1; i++) @(negedge clk);
            if (l4_int !== 1'b1) begin
                chk("level4_wait", 8'h01, b8(l4_int));
                break;
            end
            settle(2);
            chk("level1", 8'h00, b8(l1_int));
            chk("cc_lanes", 8'(k), {6'h00, completion[CC_PAR_B0 +: 2]});
            chk("l2_lanes", (k == 1) ? 8'h01 : 8'h03, {6'h00, l2_status[1:0]});
            chk("l2_pos", 8'(k), {6'h00, l2_status[5:4]});
            chk("lid", LID_TYPE_B_BASE | 8'(k), line_identifier);
        end
        issue(CMD_GET_COMPLETION);
        chk("level4", 8'h00, b8(l4_int));
        @(posedge clk);
        par_test <= 1'b0;
        rd(16'h0000, 2'b00);
        settle(8);
        chk("good_read_l4", 8'h00, b8(l4_int));
        chk("good_read_cc", 8'h00, {6'h00, completion[CC_PAR_B0 +: 2]});
        // adapter interrupts reach maintenance through position 0
        @(posedge clk);
        cb_req <= 1'b1;
        settle(3);
        chk("block_free_int", 8'h01, b8(maint_int));
        @(posedge clk);
        cb_req <= 1'b0;
        open_close <= 1'b1;
        @(posedge clk);
        open_close <= 1'b0;
        settle(3);
        chk("status_posted", 8'h01, b8(posted));
        chk("status_int", 8'h01, b8(maint_int));
        conclude();
    end
endmodule : tb
`default_nettype wire
